// ==== rtl/bmv_pkg.sv ====
// shared constants and carriers for the block move sequencer
// Behaviour
// [RULE1] byte form: while 8-bit count nonzero copy byte, bump pointers, count down
// [RULE2] byte form stops at zero count; zero at start moves nothing
// [RULE3] word form: while 16-bit count nonzero copy byte, bump pointers, count down
// [RULE4] word form stops at zero count; zero at start moves nothing
// [RULE5] either form takes eight plus four times n states
// [RULE6] that figure holds for zero-wait memory; slower memory may lengthen it
// [RULE7] condition flags come out exactly as they went in
package bmv_pkg;
    localparam int ADDR_W      = 16;
    localparam int CNT_W       = 16;
    localparam int BYTE_CNT_W  = 8;
    localparam int FLAG_W      = 8;
    localparam int BUDGET_W    = 19;
    localparam int FIFO_DEPTH  = 8;
    // fixed overhead and per-byte cost, in states
    localparam int BASE_STATES = 8;
    localparam int BYTE_STATES = 4;
    localparam logic [ADDR_W-1:0] PTR_STEP  = 16'h0001;
    localparam logic [CNT_W-1:0]  CNT_STEP  = 16'h0001;
    localparam logic [CNT_W-1:0]  CNT_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] PTR_RESET = 16'h0000;
    localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;

    typedef enum logic {
        BMV_BYTE_FORM = 1'b0,
        BMV_WORD_FORM = 1'b1
    } bmv_form_t;

    // operands of one block move instruction
    typedef struct packed {
        bmv_form_t         form;
        logic [CNT_W-1:0]  count;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
    } bmv_args_t;
endpackage

// ==== rtl/bmv_fifo.sv ====
// byte buffer between the read and write halves of the move
`timescale 1ns/1ns
module bmv_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // pointer wrap relies on a power-of-two depth; refused at elaboration
    if (WIDTH < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_cfg
        $error("bmv_fifo: depth must be a power of two, width positive");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      fill;
    logic             push;
    logic             pop;

    assign in_ready  = (fill != (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (fill != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr];

    // storage, written at the tail
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    // pointers and fill level
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + PW'(1);
            if (pop)
                rd_ptr <= rd_ptr + PW'(1);
            if (push && !pop)
                fill <= fill + (PW+1)'(1);
            else if (pop && !push)
                fill <= fill - (PW+1)'(1);
        end
    end
endmodule // bmv_fifo

// ==== rtl/bmv_pacer.sv ====
// state counter that holds back completion until the minimum time
`timescale 1ns/1ns
module bmv_pacer #(
    parameter int BW = 19
) (
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire logic          start,
    input  wire logic [BW-1:0] budget,
    output logic               reached
);
    // too narrow a budget could not even hold the fixed overhead
    if (BW < 4)
    begin : g_bad_width
        $error("bmv_pacer: budget width too small");
    end

    logic [BW-1:0] elapsed;
    logic [BW-1:0] limit;

    // elapsed states since the start edge; saturates at the limit
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            elapsed <= '0;
            limit   <= '0;
        end
        else if (start)
        begin
            elapsed <= BW'(1);
            limit   <= budget;
        end
        else if (elapsed < limit)
            elapsed <= elapsed + BW'(1);
    end

    // one state is spent by the completion pulse itself
    assign reached = (elapsed + BW'(1) >= limit) && !start;
endmodule // bmv_pacer

// ==== rtl/bmv_sequencer.sv ====
// block move sequencer: copies bytes from source to destination pointer
`timescale 1ns/1ns
module bmv_sequencer #(
    parameter int FIFO_D = bmv_pkg::FIFO_DEPTH
) (
    input  wire logic                         mclk,
    input  wire logic                         srst,
    input  wire logic                         start,
    input  wire bmv_pkg::bmv_args_t           args,
    input  wire logic [bmv_pkg::FLAG_W-1:0]   flags_in,
    output logic                              busy,
    output logic                              done,
    output logic [bmv_pkg::CNT_W-1:0]         count_out,
    output logic [bmv_pkg::ADDR_W-1:0]        src_out,
    output logic [bmv_pkg::ADDR_W-1:0]        dst_out,
    output logic [bmv_pkg::FLAG_W-1:0]        flags_out,
    output logic                              rd_req,
    output logic [bmv_pkg::ADDR_W-1:0]        rd_addr,
    input  wire logic                         rd_ack,
    input  wire logic [7:0]                   rd_data,
    output logic                              wr_req,
    output logic [bmv_pkg::ADDR_W-1:0]        wr_addr,
    output logic [7:0]                        wr_data,
    input  wire logic                         wr_ack
);
    import bmv_pkg::*;

    // a single-entry buffer would stall reads behind every write
    if (FIFO_D < 2)
    begin : g_bad_depth
        $error("bmv_sequencer: buffer depth below two");
    end

    typedef enum logic [3:0] {
        S_IDLE   = 4'h1,
        S_MOVE   = 4'h2,
        S_SETTLE = 4'h4,
        S_DONE   = 4'h8
    } bmv_state_t;

    bmv_state_t         state;
    bmv_state_t         next_state;
    bmv_form_t          form;
    logic [CNT_W-1:0]   rd_left;
    logic [CNT_W-1:0]   start_n;
    logic [BUDGET_W-1:0] budget;
    logic               take;
    logic               fifo_in_ready;
    logic               fifo_out_valid;
    logic [7:0]         fifo_out_data;
    logic               fifo_pop;
    logic               reached;
    logic               moved_all;
    logic               cnt_zero;

    // the byte form only looks at the low byte of the count
    // [RULE1] byte form count
    assign start_n = (args.form == BMV_BYTE_FORM) ?
                     {{(CNT_W-BYTE_CNT_W){1'b0}}, args.count[BYTE_CNT_W-1:0]} :
                     args.count;
    // [RULE5] eight plus four per byte
    assign budget  = BUDGET_W'(BASE_STATES) + BUDGET_W'(BYTE_STATES) * BUDGET_W'(start_n);
    assign take    = start && (state == S_IDLE);
    assign cnt_zero = (form == BMV_BYTE_FORM) ?
                      (count_out[BYTE_CNT_W-1:0] == '0) : (count_out == '0);
    assign fifo_pop = fifo_out_valid && !wr_req && (state == S_MOVE);
    assign moved_all = (rd_left == '0) && !rd_req && !fifo_out_valid
                       && !wr_req && cnt_zero;

    bmv_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .in_valid  (rd_req && rd_ack),
        .in_ready  (fifo_in_ready),
        .in_data   (rd_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data)
    );

    bmv_pacer #(
        .BW (BUDGET_W)
    ) u_pacer (
        .mclk    (mclk),
        .srst    (srst),
        .start   (take),
        .budget  (budget),
        .reached (reached)
    );

    // sequence: copy, then wait out the minimum state count
    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE:
                if (take)
                    next_state = S_MOVE;
            S_MOVE:
                // [RULE2] stop at zero
                if (moved_all)
                    next_state = S_SETTLE;
            S_SETTLE:
                // [RULE6] slow memory only lengthens
                if (reached)
                    next_state = S_DONE;
            S_DONE:
                next_state = S_IDLE;
            default:
                next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            state <= S_IDLE;
        else
            state <= next_state;
    end

    // status outputs
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            busy <= (next_state != S_IDLE);
            done <= (next_state == S_DONE);
        end
    end

    // flags are captured and returned untouched
    // [RULE7] flags kept
    always_ff @(posedge mclk)
    begin
        if (srst)
            flags_out <= FLAG_RESET;
        else if (take)
            flags_out <= flags_in;
    end

    // read side: one outstanding read, issued only with room to land it
    // [RULE3] source pointer step
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            rd_req  <= 1'b0;
            rd_left <= CNT_RESET;
            src_out <= PTR_RESET;
            rd_addr <= PTR_RESET;
            form    <= BMV_BYTE_FORM;
        end
        else if (take)
        begin
            rd_left <= start_n;
            src_out <= args.src;
            rd_addr <= args.src;
            form    <= args.form;
        end
        else if (rd_req)
        begin
            if (rd_ack)
            begin
                rd_req  <= 1'b0;
                src_out <= src_out + PTR_STEP;
                rd_addr <= src_out + PTR_STEP;
            end
        end
        // [RULE4] nothing read once none left
        else if (state == S_MOVE && rd_left != '0 && fifo_in_ready)
        begin
            rd_req  <= 1'b1;
            rd_left <= rd_left - CNT_STEP;
        end
    end

    // write side: drains the buffer, counts down per completed byte
    // [RULE1] destination step and count down
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wr_req    <= 1'b0;
            wr_addr   <= PTR_RESET;
            wr_data   <= 8'h00;
            dst_out   <= PTR_RESET;
            count_out <= CNT_RESET;
        end
        else if (take)
        begin
            dst_out   <= args.dst;
            wr_addr   <= args.dst;
            count_out <= args.count;
        end
        else if (wr_req)
        begin
            if (wr_ack)
            begin
                wr_req  <= 1'b0;
                dst_out <= dst_out + PTR_STEP;
                wr_addr <= dst_out + PTR_STEP;
                // high byte is left alone in the byte form
                if (form == BMV_BYTE_FORM)
                    count_out[BYTE_CNT_W-1:0] <= count_out[BYTE_CNT_W-1:0] - 8'h01;
                else
                    count_out <= count_out - CNT_STEP;
            end
        end
        else if (fifo_pop)
        begin
            wr_req  <= 1'b1;
            wr_data <= fifo_out_data;
        end
    end

    // checks
    logic [BUDGET_W-1:0] chk_elapsed;
    logic [BUDGET_W-1:0] chk_budget;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            chk_elapsed <= '0;
            chk_budget  <= '0;
        end
        else if (take)
        begin
            chk_elapsed <= BUDGET_W'(1);
            chk_budget  <= budget;
        end
        else if (busy)
            chk_elapsed <= chk_elapsed + BUDGET_W'(1);
    end

    a_src_step: assert property ( // [RULE1]
        @(posedge mclk) disable iff (srst)
        rd_req && rd_ack |=> src_out == $past(src_out) + PTR_STEP)
        else $error("source pointer did not advance by one");

    a_word_count_step: assert property ( // [RULE3]
        @(posedge mclk) disable iff (srst)
        wr_req && wr_ack && form == BMV_WORD_FORM |=>
        count_out == $past(count_out) - CNT_STEP && dst_out == $past(dst_out) + PTR_STEP)
        else $error("word count or destination step wrong");

    a_byte_high_kept: assert property ( // [RULE2]
        @(posedge mclk) disable iff (srst)
        busy && !take && form == BMV_BYTE_FORM |=> $stable(count_out[CNT_W-1:BYTE_CNT_W]))
        else $error("byte form touched the high count byte");

    a_zero_no_read: assert property ( // [RULE4]
        @(posedge mclk) disable iff (srst)
        take && start_n == '0 |=> (!rd_req && !wr_req)[*8])
        else $error("zero count caused a transfer");

    a_done_ends_at_zero: assert property ( // [RULE2]
        @(posedge mclk) disable iff (srst)
        done |-> cnt_zero && !rd_req && !wr_req)
        else $error("completed with bytes left");

    a_min_states: assert property ( // [RULE5]
        @(posedge mclk) disable iff (srst)
        $rose(done) |-> chk_elapsed >= chk_budget)
        else $error("completed before eight plus four n states");

    a_zero_timing: assert property ( // [RULE6]
        @(posedge mclk) disable iff (srst)
        take && start_n == '0 |-> ##[1:12] done)
        else $error("zero count move did not finish in time");

    a_flags_steady: assert property ( // [RULE7]
        @(posedge mclk) disable iff (srst)
        busy && !take |=> $stable(flags_out))
        else $error("flags changed during the move");

    a_rd_hold: assert property ( // [RULE3]
        @(posedge mclk) disable iff (srst)
        rd_req && !rd_ack |=> rd_req && $stable(rd_addr))
        else $error("read request dropped or moved before acknowledge");

    a_wr_hold: assert property ( // [RULE1]
        @(posedge mclk) disable iff (srst)
        wr_req && !wr_ack |=> wr_req && $stable(wr_addr) && $stable(wr_data))
        else $error("write request dropped or moved before acknowledge");

    a_byte_count_step: assert property ( // [RULE1]
        @(posedge mclk) disable iff (srst)
        wr_req && wr_ack && form == BMV_BYTE_FORM |=>
        count_out[BYTE_CNT_W-1:0] == $past(count_out[BYTE_CNT_W-1:0]) - 8'h01
        && dst_out == $past(dst_out) + PTR_STEP)
        else $error("byte count or destination step wrong");

    a_read_needs_left: assert property ( // [RULE2]
        @(posedge mclk) disable iff (srst)
        $rose(rd_req) |-> $past(rd_left) != '0)
        else $error("read issued with no bytes left");

    a_done_pulse: assert property ( // [RULE4]
        @(posedge mclk) disable iff (srst)
        done |=> !done && !busy)
        else $error("completion did not release the sequencer");
endmodule // bmv_sequencer

// ==== dv/bmv_mem_model.sv ====
// memory model answering the sequencer's byte reads and writes
`timescale 1ns/1ns
module bmv_mem_model (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic [2:0]  rd_lat,
    input  wire logic [2:0]  wr_lat,
    input  wire logic        rd_req,
    input  wire logic [15:0] rd_addr,
    output logic             rd_ack,
    output logic [7:0]       rd_data,
    input  wire logic        wr_req,
    output logic             wr_ack
);
    logic [2:0] rd_wait;
    logic [2:0] wr_wait;
    logic [7:0] noise;

    // wait counters restart per access; latency must not change mid-access
    always_ff @(posedge mclk)
    begin
        rd_wait <= (srst || !rd_req || rd_ack) ? 3'h0 : rd_wait + 3'h1;
        wr_wait <= (srst || !wr_req || wr_ack) ? 3'h0 : wr_wait + 3'h1;
        noise   <= srst ? 8'h3C : noise + 8'h35;
    end

    // zero latency acks in the cycle the request shows
    assign rd_ack  = rd_req && (rd_wait == rd_lat);
    assign wr_ack  = wr_req && (wr_wait == wr_lat);
    // outside an ack the read bus churns, so a stale byte is never mistaken for data
    assign rd_data = rd_ack ? (rd_addr[7:0] ^ rd_addr[15:8] ^ 8'hA5) : noise;
endmodule // bmv_mem_model

// ==== dv/block_move_sequencer_test.sv ====
// self-checking bench for the block move sequencer
`timescale 1ns/1ns
module block_move_sequencer_test;
    import bmv_pkg::*;
    typedef struct {
        logic [15:0] cnt;
        logic [15:0] src;
        logic [15:0] dst;
        logic [7:0]  fl;
        int          lo;
        int          hi;
    } bmv_done_t;
    logic        mclk;
    logic        srst;
    logic        start;
    bmv_args_t   args;
    logic [7:0]  flags_in;
    logic        busy;
    logic        done;
    logic [15:0] count_out;
    logic [15:0] src_out;
    logic [15:0] dst_out;
    logic [7:0]  flags_out;
    logic        rd_req;
    logic [15:0] rd_addr;
    logic        rd_ack;
    logic [7:0]  rd_data;
    logic        wr_req;
    logic [15:0] wr_addr;
    logic [7:0]  wr_data;
    logic        wr_ack;
    logic [2:0]  rd_lat;
    logic [2:0]  wr_lat;
    int          fails;
    int          samples_checked;
    int          seed;
    time         t0;
    logic [23:0] wq[$];
    bmv_done_t   dq[$];

    bmv_sequencer #(.FIFO_D(8)) dut (
        .mclk(mclk), .srst(srst), .start(start), .args(args), .flags_in(flags_in),
        .busy(busy), .done(done), .count_out(count_out), .src_out(src_out),
        .dst_out(dst_out), .flags_out(flags_out), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_ack(wr_ack)
    );
    bmv_mem_model mem (
        .mclk(mclk), .srst(srst), .rd_lat(rd_lat), .wr_lat(wr_lat), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req),
        .wr_ack(wr_ack)
    );

    // free-running clock, 4 ns period
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic miss(input string msg);
        $display("unexpected at %0t: %s", $time, msg);
        fails++;
    endtask

    task automatic chk_write(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
            miss($sformatf("write %h, want %h", got, exp));
    endtask

    task automatic chk_done(input bmv_done_t e, input int el);
        samples_checked++;
        if ({count_out, src_out, dst_out, flags_out} !== {e.cnt, e.src, e.dst, e.fl}
            || busy !== 1'b1 || el < e.lo || el > e.hi)
            miss($sformatf("done %h %h %h %h after %0d", count_out, src_out, dst_out,
                           flags_out, el));
    endtask

    task automatic summarize;
        $display("checked %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // watcher: each write and each completion takes the oldest note
    always @(posedge mclk)
    begin
        if (!srst && wr_req === 1'b1 && wr_ack === 1'b1)
        begin
            if (wq.size() == 0)
                miss("write with nothing expected");
            else
                chk_write({wr_addr, wr_data}, wq.pop_front());
        end
        if (!srst && done === 1'b1)
        begin
            if (dq.size() == 0)
                miss("done with nothing expected");
            else
                chk_done(dq.pop_front(), int'(($time - t0) / 4));
        end
    end

    // one move; poke tries a second start while busy, which must be ignored
    task automatic move(input logic form, input logic [15:0] cnt, input logic [15:0] src,
                        input logic [15:0] dst, input logic [7:0] fl, input logic poke);
        int          n;
        int          k;
        logic [15:0] a;
        bmv_done_t   e;
        n = form ? int'(cnt) : int'(cnt[7:0]);
        for (k = 0; k < n; k++)
        begin
            a = src + 16'(k);
            wq.push_back({dst + 16'(k), a[7:0] ^ a[15:8] ^ 8'hA5});
        end
        e.cnt = form ? 16'h0000 : {cnt[15:8], 8'h00};
        e.src = src + 16'(n);
        e.dst = dst + 16'(n);
        e.fl = fl;
        @(posedge mclk);
        // latencies set just before the call have landed by now
        e.lo = 8 + 4 * n;
        e.hi = (n == 0 || (rd_lat == 3'h0 && wr_lat == 3'h0)) ? 8 + 4 * n : 1000000;
        dq.push_back(e);
        start <= 1'b1;
        args <= '{form: bmv_form_t'(form), count: cnt, src: src, dst: dst};
        flags_in <= fl;
        @(posedge mclk);
        t0 = $time;
        start <= 1'b0;
        if (poke)
        begin
            repeat (3) @(posedge mclk);
            start <= 1'b1;
            args <= 49'($random(seed));
            flags_in <= ~fl;
            @(posedge mclk);
            start <= 1'b0;
        end
        k = 0;
        while (dq.size() != 0 && k < 20000)
        begin
            @(posedge mclk);
            k++;
        end
        if (k == 20000)
        begin
            miss("no completion");
            summarize();
        end
        @(posedge mclk);
    endtask

    // main sequence: zero counts, boundaries, slow memory, random mix
    initial
    begin
        seed = 97104;
        srst = 1'b1;
        start = 1'b0;
        args = '0;
        flags_in = 8'h00;
        rd_lat = 3'h0;
        wr_lat = 3'h0;
        fails = 0;
        samples_checked = 0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        move(1'b0, 16'h3400, 16'h1000, 16'h2000, 8'hC3, 1'b0);
        move(1'b1, 16'h0000, 16'h1000, 16'h2000, 8'h3C, 1'b0);
        move(1'b0, 16'h1203, 16'h00FE, 16'h4000, 8'hA5, 1'b0);
        move(1'b1, 16'h0102, 16'hFFF0, 16'h2000, 8'h5A, 1'b0);
        wr_lat <= 3'h7;
        move(1'b1, 16'h0014, 16'h0300, 16'h0800, 8'hFF, 1'b1);
        rd_lat <= 3'h5;
        wr_lat <= 3'h0;
        move(1'b0, 16'h0009, 16'h7FFC, 16'hFFFE, 8'h81, 1'b1);
        repeat (6)
        begin
            rd_lat <= 3'($random(seed));
            wr_lat <= 3'($random(seed));
            move(1'($random(seed)), 16'($random(seed)) & 16'h013F, 16'($random(seed)),
                 16'($random(seed)), 8'($random(seed)), 1'b0);
        end
        summarize();
    end
endmodule // block_move_sequencer_test
